// *** inc/irq_prio_map.svh ***
// Register offsets, field positions, reset values and sizes of the interrupt block
`ifndef IRQ_PRIO_MAP_SVH
`define IRQ_PRIO_MAP_SVH
// ----------------------------------------
// Register indices (byte address = 4 x index)
// ----------------------------------------
`define IDX_PRIO_FOUR 12'hf90
`define IDX_PRIO_FIVE 12'hf99
`define IDX_PRIO_THREE 12'hfa5
`define IDX_RESET_CTRL 12'hfd0
`define IDX_CTRL_MAIN 12'hff2
`define IDX_CTRL_SECOND 12'hff1
`define IDX_CTRL_THIRD 12'hff0
`define IDX_TMR0_CTRL 12'hfd5
`define IDX_TMR0_COUNT 12'hfd6
// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_PRIO_FULL 8'hff
`define RST_PRIO_FIVE 6'h3f
`define RST_RESET_CTRL 8'h3c
// ----------------------------------------
// Field positions
// ----------------------------------------
`define BIT_PRIO_EN 7
`define BIT_GIE_HIGH 7
`define BIT_GIE_LOW 6
`define BIT_TMR0_IE 5
`define BIT_EXT0_IE 4
`define BIT_PORTB_IE 3
`define BIT_TMR0_IF 2
`define BIT_EXT0_IF 1
`define BIT_PORTB_IF 0
`define BIT_EXT2_PRIO 7
`define BIT_EXT1_PRIO 6
`define BIT_EXT3_PRIO 1
`define BIT_TMR0_PRIO 2
`define BIT_PORTB_PRIO 0
`define BIT_TMR0_RUN 0
`define BIT_TMR0_WIDE 1
// ----------------------------------------
// Sizes
// ----------------------------------------
`define PERIPH_SRC 22
`define STACK_DEPTH 5'd31
`endif

// *** inc/irq_prio_pkg.sv ***
// Types shared by the interrupt priority block
package irq_prio_pkg;
  // Context captured when an interrupt is taken
  typedef struct packed {
    logic [20:0] pc;
    logic [7:0] workingReg;
    logic [7:0] status;
    logic [7:0] bankSelect;
  } ctx_s;
  // Which level is in service
  typedef enum logic [1:0] {LVL_NONE, LVL_LOW, LVL_HIGH} level_e;
endpackage : irq_prio_pkg

// *** core/irq_prio_ctrl.sv ***
// Interrupt priority, external edge interrupts, timer zero and context save
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/10ps
`include "irq_prio_map.svh"
module irq_prio_ctrl (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] extIrqPin,
  input wire logic [3:0] portBHigh,
  input wire logic [`PERIPH_SRC-1:0] periphReq,
  input wire logic watchdogTimeoutIn,
  input wire logic powerDownIn,
  input wire logic deepSleepIn,
  input wire logic entryAck,
  input wire irq_prio_pkg::ctx_s ctxIn,
  input wire logic retfie,
  output logic irqReq,
  output logic irqVecHigh,
  output logic wakeReq,
  output logic deepWake,
  output irq_prio_pkg::ctx_s retCtx
);
  import irq_prio_pkg::*;

  // Reset value as a vector, so that single cause bits can be picked from it
  localparam logic [7:0] resetCtrlInit = `RST_RESET_CTRL;

  // ----------------------------------------
  // Register decode
  // ----------------------------------------
  // Word index of an APB byte address
  function automatic logic [11:0] regIdx(input logic [13:0] a);
    regIdx = a[13:2];
  endfunction : regIdx

  // True when the index names a register of this block
  function automatic logic isMapped(input logic [11:0] i);
    isMapped = (i == `IDX_PRIO_FOUR) || (i == `IDX_PRIO_FIVE) ||
      (i == `IDX_PRIO_THREE) || (i == `IDX_RESET_CTRL) ||
      (i == `IDX_CTRL_MAIN) || (i == `IDX_CTRL_SECOND) ||
      (i == `IDX_CTRL_THIRD) || (i == `IDX_TMR0_CTRL) ||
      (i == `IDX_TMR0_COUNT);
  endfunction : isMapped

  logic [11:0] idx; // Index of current address
  logic wrAcc; // Write takes effect this cycle
  logic [7:0] wb; // Low write byte

  assign idx = regIdx(paddr);
  assign wrAcc = psel && penable && pwrite;
  assign wb = pwdata[7:0];
  // Zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && !isMapped(idx);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [7:0] prioThree_q; // Serial, UART two, timers, calendar
  logic [7:0] prioFour_q; // Capture units
  logic [5:0] prioFive_q; // Comparator and timer sources
  logic prioLevelsEnable_q; // Two-level mode
  logic [3:0] causeFlags_q; // Config mismatch, reset instr, power-on, brown-out
  logic [7:0] ctrlMain_q; // Globals, enables, flags
  logic [7:0] ctrlSecond_q; // Edge selects and priorities
  logic [7:0] ctrlThird_q; // Ext 2..1 priorities, ext 3..1 enables and flags
  logic [1:0] tmr0Ctrl_q; // Run and sixteen-bit mode
  logic [15:0] tmr0Count_q; // Timer zero counter
  logic [3:0] pinPrev_q; // Last sampled external pins
  logic [3:0] portBPrev_q; // Last sampled port B upper pins
  logic deepWake_q; // Deep sleep wake pulse
  logic [31:0] prdata_q; // Read data latched in setup

  // ----------------------------------------
  // Priority registers
  // ----------------------------------------
  // Reset to all-high; any source bit is plain RW
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prioThree_q <= `RST_PRIO_FULL;
      prioFour_q <= `RST_PRIO_FULL;
      prioFive_q <= `RST_PRIO_FIVE;
    end else if (wrAcc) begin
      if (idx == `IDX_PRIO_THREE) prioThree_q <= wb;
      if (idx == `IDX_PRIO_FOUR) prioFour_q <= wb;
      if (idx == `IDX_PRIO_FIVE) prioFive_q <= wb[5:0];
    end
  end

  // ----------------------------------------
  // Reset control register
  // ----------------------------------------
  // Timeout and power-down come from the reset logic and are read-only
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prioLevelsEnable_q <= 1'b0;
      causeFlags_q <= {resetCtrlInit[5], resetCtrlInit[4],
                       resetCtrlInit[1], resetCtrlInit[0]};
    end else if (wrAcc && idx == `IDX_RESET_CTRL) begin
      prioLevelsEnable_q <= wb[`BIT_PRIO_EN];
      causeFlags_q <= {wb[5], wb[4], wb[1], wb[0]};
    end
  end

  // ----------------------------------------
  // Edge and change detection
  // ----------------------------------------
  logic [3:0] edgeSel; // One per pin: 1 rising, 0 falling
  logic [3:0] extEdge; // Selected edge seen
  logic portBChange; // Any upper port B change
  logic tmr0Roll; // Timer zero rollover this cycle

  assign edgeSel = ctrlSecond_q[7:4];
  // Pins are taken as synchronous; previous sample makes the edge
  assign extEdge = (edgeSel & extIrqPin & ~pinPrev_q) |
                   (~edgeSel & ~extIrqPin & pinPrev_q);
  assign portBChange = |(portBHigh ^ portBPrev_q);

  // Pin history
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pinPrev_q <= 4'h0;
      portBPrev_q <= 4'h0;
    end else begin
      pinPrev_q <= extIrqPin;
      portBPrev_q <= portBHigh;
    end
  end

  // ----------------------------------------
  // Timer zero
  // ----------------------------------------
  // In eight-bit mode the high byte is frozen so rollover is FFh to 00h
  assign tmr0Roll = tmr0Ctrl_q[`BIT_TMR0_RUN] &&
    (tmr0Ctrl_q[`BIT_TMR0_WIDE] ? (tmr0Count_q == 16'hffff)
                                : (tmr0Count_q[7:0] == 8'hff));

  // Counter and its control; a control write restarts the count
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tmr0Ctrl_q <= 2'h0;
      tmr0Count_q <= 16'h0000;
    end else if (wrAcc && idx == `IDX_TMR0_CTRL) begin
      tmr0Ctrl_q <= wb[1:0];
      tmr0Count_q <= 16'h0000;
    end else if (tmr0Ctrl_q[`BIT_TMR0_RUN]) begin
      if (tmr0Ctrl_q[`BIT_TMR0_WIDE]) begin
        tmr0Count_q <= tmr0Count_q + 16'h0001;
      end else begin
        tmr0Count_q[7:0] <= tmr0Count_q[7:0] + 8'h01;
      end
    end
  end

  // ----------------------------------------
  // Control registers with sticky flags
  // ----------------------------------------
  // A hardware set in the same cycle as a software clear wins, so no
  // event is lost; software clears a flag by writing it with zero
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrlMain_q <= 8'h00;
    end else begin
      if (wrAcc && idx == `IDX_CTRL_MAIN) begin
        ctrlMain_q <= wb;
      end
      if (tmr0Roll) ctrlMain_q[`BIT_TMR0_IF] <= 1'b1;
      if (extEdge[0]) ctrlMain_q[`BIT_EXT0_IF] <= 1'b1;
      if (portBChange) ctrlMain_q[`BIT_PORTB_IF] <= 1'b1;
    end
  end

  // Edge selects and priorities; bit 3 is not used
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrlSecond_q <= 8'h00;
    end else if (wrAcc && idx == `IDX_CTRL_SECOND) begin
      ctrlSecond_q <= {wb[7:4], 1'b0, wb[2:0]};
    end
  end

  // Bits 5..3 enable ext 3..1, bits 2..0 flag ext 3..1
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrlThird_q <= 8'h00;
    end else begin
      if (wrAcc && idx == `IDX_CTRL_THIRD) begin
        ctrlThird_q <= wb;
      end
      for (int i = 1; i < 4; i++) begin
        if (extEdge[i]) ctrlThird_q[i-1] <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Pending requests by level
  // ----------------------------------------
  logic [3:0] extFlag; // External flags, pin order
  logic [3:0] extEn; // External enables, pin order
  logic [3:0] extPrio; // External priorities, pin order
  logic [`PERIPH_SRC-1:0] periphPrio; // Peripheral priority bits
  logic tmr0Pend; // Timer zero flagged and enabled
  logic portBPend; // Port B change flagged and enabled
  logic highPend; // Some high request
  logic lowPend; // Some low request

  assign extFlag = {ctrlThird_q[2:0], ctrlMain_q[`BIT_EXT0_IF]};
  assign extEn = {ctrlThird_q[5:3], ctrlMain_q[`BIT_EXT0_IE]};
  // Pin zero has no priority bit and is tied high
  assign extPrio = {ctrlSecond_q[`BIT_EXT3_PRIO], ctrlThird_q[`BIT_EXT2_PRIO],
                    ctrlThird_q[`BIT_EXT1_PRIO], 1'b1};
  assign periphPrio = {prioFive_q, prioFour_q, prioThree_q};
  assign tmr0Pend = ctrlMain_q[`BIT_TMR0_IF] && ctrlMain_q[`BIT_TMR0_IE];
  assign portBPend = ctrlMain_q[`BIT_PORTB_IF] && ctrlMain_q[`BIT_PORTB_IE];

  // A disabled request never reaches the core, whatever its flag
  assign highPend = |(extFlag & extEn & extPrio) |
    |(periphReq & periphPrio) |
    (tmr0Pend && ctrlSecond_q[`BIT_TMR0_PRIO]) |
    (portBPend && ctrlSecond_q[`BIT_PORTB_PRIO]);
  assign lowPend = |(extFlag & extEn & ~extPrio) |
    |(periphReq & ~periphPrio) |
    (tmr0Pend && !ctrlSecond_q[`BIT_TMR0_PRIO]) |
    (portBPend && !ctrlSecond_q[`BIT_PORTB_PRIO]);

  // ----------------------------------------
  // Arbitration and nesting
  // ----------------------------------------
  logic inHigh_q; // High routine running
  logic inLow_q; // Low routine running
  logic highOk; // High request may be taken
  logic lowOk; // Low request may be taken
  logic gieHigh; // Global high enable
  logic gieLow; // Global low enable

  assign gieHigh = ctrlMain_q[`BIT_GIE_HIGH];
  assign gieLow = ctrlMain_q[`BIT_GIE_LOW];
  // Legacy mode: one level, everything through the high vector
  assign highOk = prioLevelsEnable_q ? (gieHigh && highPend && !inHigh_q)
    : (gieHigh && (highPend || lowPend) && !inHigh_q);
  // A low request waits for any running routine; high can preempt low
  assign lowOk = prioLevelsEnable_q && gieHigh && gieLow && lowPend &&
    !inHigh_q && !inLow_q;
  assign irqReq = highOk || lowOk;
  assign irqVecHigh = highOk;

  // In-service tracking; return leaves the innermost level first
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      inHigh_q <= 1'b0;
      inLow_q <= 1'b0;
    end else if (entryAck && irqReq) begin
      if (highOk) inHigh_q <= 1'b1;
      else inLow_q <= 1'b1;
    end else if (retfie) begin
      if (inHigh_q) inHigh_q <= 1'b0;
      else inLow_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Return stack and shadow context
  // ----------------------------------------
  logic [20:0] retStack [0:30]; // Return addresses
  logic [4:0] sp_q; // Entries in use
  ctx_s shadow_q; // Fast return copy
  ctx_s retCtx_q; // Context handed back on return

  // Stack pointer; a full stack drops further pushes
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sp_q <= 5'd0;
    end else if (entryAck && irqReq) begin
      if (sp_q < `STACK_DEPTH) sp_q <= sp_q + 5'd1;
    end else if (retfie && sp_q != 5'd0) begin
      sp_q <= sp_q - 5'd1;
    end
  end

  // Stack storage has no reset; only pushed entries are ever read
  always_ff @(posedge core_clk) begin
    if (entryAck && irqReq && sp_q < `STACK_DEPTH) begin
      retStack[sp_q] <= ctxIn.pc;
    end
  end

  // Shadow copy of working, status and bank registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      shadow_q <= '0;
    end else if (entryAck && irqReq) begin
      shadow_q <= ctxIn;
    end
  end

  // Returned context: popped address plus shadowed registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      retCtx_q <= '0;
    end else if (retfie && sp_q != 5'd0) begin
      retCtx_q <= shadow_q;
      retCtx_q.pc <= retStack[sp_q - 5'd1];
    end
  end
  assign retCtx = retCtx_q;

  // ----------------------------------------
  // Wake logic
  // ----------------------------------------
  // Enable must already be set; a flag raised while asleep then wakes
  assign wakeReq = |(extFlag & extEn);

  // Deep sleep wake restarts at the reset vector, so it is a pulse
  // to the power logic rather than an interrupt
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      deepWake_q <= 1'b0;
    end else begin
      deepWake_q <= deepSleepIn && extEdge[0];
    end
  end
  assign deepWake = deepWake_q;

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  // Read data is caught in the setup cycle and held through access
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable) begin
      unique case (idx)
        `IDX_PRIO_THREE: prdata_q <= {24'h00_0000, prioThree_q};
        `IDX_PRIO_FOUR: prdata_q <= {24'h00_0000, prioFour_q};
        `IDX_PRIO_FIVE: prdata_q <= {24'h00_0000, 2'b00, prioFive_q};
        `IDX_RESET_CTRL: prdata_q <= {24'h00_0000, prioLevelsEnable_q, 1'b0,
          causeFlags_q[3:2], watchdogTimeoutIn, powerDownIn,
          causeFlags_q[1:0]};
        `IDX_CTRL_MAIN: prdata_q <= {24'h00_0000, ctrlMain_q};
        `IDX_CTRL_SECOND: prdata_q <= {24'h00_0000, ctrlSecond_q};
        `IDX_CTRL_THIRD: prdata_q <= {24'h00_0000, ctrlThird_q};
        `IDX_TMR0_CTRL: prdata_q <= {24'h00_0000, 6'h00, tmr0Ctrl_q};
        `IDX_TMR0_COUNT: prdata_q <= {16'h0000, tmr0Count_q};
        default: prdata_q <= 32'h0000_0000;
      endcase
    end
  end
  assign prdata = prdata_q;

endmodule : irq_prio_ctrl

// *** tb/irq_prio_ctrl_props.sv ***
// Concurrent checks on the ports of the interrupt priority block
`timescale 1ns/10ps
`include "irq_prio_map.svh"
module irq_prio_ctrl_props (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic watchdogTimeoutIn,
  input wire logic powerDownIn,
  input wire logic deepSleepIn,
  input wire logic entryAck,
  input wire logic irqReq,
  input wire logic irqVecHigh,
  input wire logic retfie,
  input wire logic deepWake,
  input wire irq_prio_pkg::ctx_s retCtx
);
  import irq_prio_pkg::*;
  // ----------------------------------------
  // Shared clocking
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic rdAcc;
  // Read access cycle, where read data values are judged; hold is checked in the other cycles
  assign rdAcc = psel && penable && !pwrite;
  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  a_err_access: assert property (pslverr |-> psel && penable)
    else $error("error flag outside access");
  a_rdata_hold: assert property (!(psel && !penable) |=> $stable(prdata))
    else $error("read data moved without setup");
  a_upper_zero: assert property (rdAcc |-> prdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  a_five_unimpl: assert property (rdAcc && paddr == {`IDX_PRIO_FIVE, 2'b00}
    |-> prdata[7:6] == 2'b00)
    else $error("unimplemented bits not zero");
  a_cause_flags: assert property (rdAcc && paddr == {`IDX_RESET_CTRL, 2'b00}
    |-> !prdata[6] && prdata[3:2] == $past({watchdogTimeoutIn, powerDownIn}))
    else $error("cause flags wrong");
  // ----------------------------------------
  // Interrupt entry, return and wake
  // ----------------------------------------
  a_high_taken: assert property (entryAck && irqReq && irqVecHigh |=> !irqReq)
    else $error("high request not dropped");
  a_low_taken: assert property (entryAck && irqReq && !irqVecHigh
    |=> !irqReq || irqVecHigh)
    else $error("low request not dropped");
  a_ret_update: assert property (!$stable(retCtx) |-> $past(retfie))
    else $error("return context moved alone");
  a_deep_pulse: assert property (deepWake |-> $past(deepSleepIn) ##1 !deepWake)
    else $error("deep wake not a pulse");
endmodule : irq_prio_ctrl_props

bind irq_prio_ctrl irq_prio_ctrl_props u_props (.core_clk, .rst, .psel, .penable, .pwrite,
  .paddr, .prdata, .pslverr, .watchdogTimeoutIn, .powerDownIn, .deepSleepIn, .entryAck,
  .irqReq, .irqVecHigh, .retfie, .deepWake, .retCtx);

// *** tb/cpu_core_model.sv ***
// Core model that acknowledges requests and presents its context
`timescale 1ns/10ps
module cpu_core_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic irqReq,
  input wire logic ackOn,
  output logic entryAck,
  output irq_prio_pkg::ctx_s ctxIn
);
  import irq_prio_pkg::*;
  // One-cycle acknowledge; ackOn low models a slow core
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      entryAck <= 1'b0;
    end else begin
      entryAck <= irqReq && ackOn && !entryAck;
    end
  end
  // Context changes every cycle so a late capture is caught
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctxIn <= '0;
    end else begin
      ctxIn.pc <= ctxIn.pc + 21'h0_0001;
      ctxIn.workingReg <= ~ctxIn.workingReg;
      ctxIn.status <= ctxIn.status + 8'h03;
      ctxIn.bankSelect <= ctxIn.pc[7:0];
    end
  end
endmodule : cpu_core_model

// *** tb/tb_interrupt_priority_and_external_irq.sv ***
// Self-checking bench for the interrupt priority block
`timescale 1ns/10ps
`include "irq_prio_map.svh"
module tb_interrupt_priority_and_external_irq;
  import irq_prio_pkg::*;
  logic core_clk, rst, psel, penable, pwrite, pready, pslverr, err, vh, wk, seen;
  logic watchdogTimeoutIn, powerDownIn, deepSleepIn, entryAck, retfie, ackOn;
  logic irqReq, irqVecHigh, wakeReq, deepWake;
  logic [13:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] extIrqPin, portBHigh;
  logic [`PERIPH_SRC-1:0] periphReq;
  ctx_s ctxIn, retCtx, savedCtx;
  int nMismatch, checked;
  irq_prio_ctrl u_dut (.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .extIrqPin, .portBHigh, .periphReq, .watchdogTimeoutIn,
    .powerDownIn, .deepSleepIn, .entryAck, .ctxIn, .retfie, .irqReq, .irqVecHigh, .wakeReq,
    .deepWake, .retCtx);
  cpu_core_model u_cpu (.core_clk, .rst, .irqReq, .ackOn, .entryAck, .ctxIn);
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // Context the core handed over at the last entry
  always @(posedge core_clk) if (entryAck && irqReq) savedCtx <= ctxIn;
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic print_verdict();
    if (nMismatch == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      nMismatch++;
      $display("unexpected %0t got %0h want %0h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer, held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] idx, input logic [7:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h00_0000, d};
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge core_clk); n++; end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin nMismatch++; print_verdict(); end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb
  task automatic rchk(input logic [11:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rd, {56'h0, exp});
  endtask : rchk
  // Bounded wait on the request level, sampled at the falling edge
  task automatic wait_irq(input logic v);
    int n;
    n = 0;
    do begin @(negedge core_clk); n++; end while (irqReq !== v && n < 50);
    if (irqReq !== v) begin nMismatch++; print_verdict(); end
    vh = irqVecHigh;
    wk = wakeReq;
    @(posedge core_clk);
  endtask : wait_irq
  task automatic ret();
    retfie <= 1'b1;
    @(posedge core_clk);
    retfie <= 1'b0;
    @(negedge core_clk);
    @(posedge core_clk);
  endtask : ret
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    rchk(`IDX_PRIO_THREE, 8'hff);
    rchk(`IDX_PRIO_FOUR, 8'hff);
    rchk(`IDX_PRIO_FIVE, 8'h3f);
    rchk(`IDX_RESET_CTRL, 8'h3c);
    apb(1'b1, `IDX_PRIO_THREE, 8'h5a);
    rchk(`IDX_PRIO_THREE, 8'h5a);
    apb(1'b1, `IDX_PRIO_FIVE, 8'hff);
    rchk(`IDX_PRIO_FIVE, 8'h3f);
    powerDownIn <= 1'b0;
    apb(1'b1, `IDX_RESET_CTRL, 8'hff);
    rchk(`IDX_RESET_CTRL, 8'hbb);
    powerDownIn <= 1'b1;
    apb(1'b0, 12'h000, 8'h00);
    chk(err, 1'b1);
    chk(rd, 32'h0000_0000);
  endtask : t_regs
  task automatic t_ext0();
    apb(1'b1, `IDX_RESET_CTRL, 8'hb0);
    apb(1'b1, `IDX_CTRL_MAIN, 8'hd0);
    apb(1'b1, `IDX_CTRL_SECOND, 8'h10);
    extIrqPin[0] <= 1'b1;
    wait_irq(1'b1);
    chk(vh, 1'b1);
    chk(wk, 1'b1);
    ackOn <= 1'b1;
    wait_irq(1'b0);
    ackOn <= 1'b0;
    rchk(`IDX_CTRL_MAIN, 8'hd2);
    apb(1'b1, `IDX_CTRL_MAIN, 8'hd0);
    ret();
    chk(retCtx, savedCtx);
  endtask : t_ext0
  // Falling edge at low level, then preempted by pin zero
  task automatic t_ext1();
    apb(1'b1, `IDX_CTRL_THIRD, 8'h08);
    apb(1'b1, `IDX_CTRL_SECOND, 8'h00);
    extIrqPin[1] <= 1'b0;
    wait_irq(1'b1);
    chk(vh, 1'b0);
    ackOn <= 1'b1;
    wait_irq(1'b0);
    ackOn <= 1'b0;
    apb(1'b1, `IDX_CTRL_THIRD, 8'h08);
    extIrqPin[0] <= 1'b0;
    wait_irq(1'b1);
    chk(vh, 1'b1);
    ackOn <= 1'b1;
    wait_irq(1'b0);
    ackOn <= 1'b0;
    apb(1'b1, `IDX_CTRL_MAIN, 8'hd0);
    ret();
    chk(retCtx, savedCtx);
    ret();
  endtask : t_ext1
  // Peripheral levels follow their priority bit: third register holds 5a
  task automatic t_periph();
    periphReq <= 22'h00_0001;
    wait_irq(1'b1);
    chk(vh, 1'b0);
    periphReq <= 22'h00_0002;
    wait_irq(1'b1);
    chk(vh, 1'b1);
    periphReq <= 22'h00_0000;
    wait_irq(1'b0);
  endtask : t_periph
  task automatic t_tmr();
    apb(1'b1, `IDX_CTRL_MAIN, 8'h00);
    apb(1'b1, `IDX_TMR0_CTRL, 8'h01);
    repeat (240) @(posedge core_clk);
    rchk(`IDX_CTRL_MAIN, 8'h00);
    repeat (20) @(posedge core_clk);
    rchk(`IDX_CTRL_MAIN, 8'h04);
    chk(irqReq, 1'b0);
    apb(1'b1, `IDX_CTRL_SECOND, 8'h04);
    apb(1'b1, `IDX_CTRL_MAIN, 8'ha4);
    wait_irq(1'b1);
    chk(vh, 1'b1);
    apb(1'b1, `IDX_CTRL_MAIN, 8'h00);
    apb(1'b1, `IDX_TMR0_CTRL, 8'h00);
  endtask : t_tmr
  task automatic t_misc();
    apb(1'b1, `IDX_CTRL_MAIN, 8'h08);
    portBHigh <= 4'h4;
    repeat (2) @(posedge core_clk);
    rchk(`IDX_CTRL_MAIN, 8'h09);
    apb(1'b1, `IDX_CTRL_MAIN, 8'h00);
    apb(1'b1, `IDX_CTRL_SECOND, 8'h10);
    deepSleepIn <= 1'b1;
    extIrqPin[0] <= 1'b1;
    seen = 1'b0;
    repeat (6) begin @(negedge core_clk); seen = seen | (deepWake === 1'b1); end
    chk(seen, 1'b1);
    @(posedge core_clk);
    deepSleepIn <= 1'b0;
    // Legacy mode: a low-priority port B change must still reach the high vector
    apb(1'b1, `IDX_RESET_CTRL, 8'h30);
    apb(1'b1, `IDX_CTRL_MAIN, 8'h89);
    wait_irq(1'b1);
    chk(vh, 1'b1);
  endtask : t_misc
  // ----------------------------------------
  // Main sequence and hang guard
  // ----------------------------------------
  initial begin
    {rst, psel, penable, pwrite, retfie, ackOn, deepSleepIn} = 7'b1000000;
    {watchdogTimeoutIn, powerDownIn} = 2'b11;
    paddr = 14'h0000;
    pwdata = 32'h0000_0000;
    extIrqPin = 4'he;
    portBHigh = 4'h0;
    periphReq = 22'h00_0000;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    t_regs();
    t_ext0();
    t_ext1();
    t_periph();
    t_tmr();
    t_misc();
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    nMismatch++;
    print_verdict();
  end
endmodule : tb_interrupt_priority_and_external_irq
